/* hdl/sysopt_pkg.sv */
// Package of the system option register bank: register select codes,
// field positions and reset values. Assumes an 8-bit CPU data path.
package sysopt_pkg;
	// Register select codes on the CPU register port
	localparam logic [1:0] SYSOPT_SEL_DBG = 2'h0;
	localparam logic [1:0] SYSOPT_SEL_OPT1 = 2'h1;
	localparam logic [1:0] SYSOPT_SEL_OPT2 = 2'h2;
	// Debug force reset register
	localparam int SYSOPT_FRC_BIT = 0;
	localparam logic [7:0] SYSOPT_DBG_READ = 8'h00;
	// Option register one fields
	localparam int SYSOPT_O1_WDOG_EN = 7;
	localparam int SYSOPT_O1_WDOG_LONG = 6;
	localparam int SYSOPT_O1_STOP_OK = 5;
	localparam int SYSOPT_O1_RSVD = 4;
	localparam int SYSOPT_O1_DBG_PIN = 1;
	localparam int SYSOPT_O1_RST_PIN = 0;
	// Bits that store a written value (bits 3 and 2 read zero)
	localparam logic [7:0] SYSOPT_O1_MASK = 8'hF3;
	// Reset value without the reset pin enable, which is kept apart
	localparam logic [7:0] SYSOPT_O1_RESET = 8'hD2;
	localparam logic SYSOPT_RESET_PIN_ENABLE_POR = 1'h0;
	// Option register two fields
	localparam int SYSOPT_O2_WDOG_CLK = 7;
	localparam int SYSOPT_O2_I2C_PIN = 1;
	localparam int SYSOPT_O2_CMP_CAP = 0;
	localparam logic SYSOPT_O2_CLK_RESET = 1'h0;
	localparam logic SYSOPT_O2_I2C_RESET = 1'h0;
	localparam logic SYSOPT_O2_CMP_RESET = 1'h0;
	// State of the bank apart from the reset pin enable, registered as one word
	typedef struct packed {
		logic [7:0] opt1;
		logic opt1_locked;
		logic wdog_clk_sel;
		logic wdog_clk_locked;
		logic i2c_pin_sel;
		logic cmp_to_cap;
		logic [7:0] rdata;
		logic force_reset;
		logic srs_clear;
		logic wdog_tick;
		logic illegal_stop;
		logic stop_enter;
		logic timer_ch0;
	} sysopt_state_t;
endpackage

/* hdl/sysopt_bank.sv */
// System option register bank: debug force reset, write-once option one,
// option two with a write-once watchdog clock select.
// Assumes rst_in is any MCU reset and por_lvd_in is held high with it
// when that reset is a power-on or low-voltage reset.
// Summary of operation
// - Force reset register always reads zero
// - User program writes to force reset ignored
// - Debug write of one forces MCU reset
// - Option one: first write only, read anytime
// - Reserved bit four stores, controls nothing
// - Bit seven enables watchdog timeout reset
// - Bit six selects short or long timeout
// - Stop without allow gives illegal opcode reset
// - Bit one selects debug pin function
// - Debug pin enable reads one after reset
// - Bit zero gives reset pin with pullup
// - Reset pin enable clears on power resets
// - Option two bit seven picks watchdog clock
// - Watchdog clock select is write-once
// - Option two bit one places I2C pins
// - Option two bit zero routes comparator capture
// - Forced reset clears reset source flags
module sysopt_bank
	import sysopt_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic por_lvd_in,
	input wire logic [1:0] cpu_sel_in,
	input wire logic cpu_rd_in,
	input wire logic cpu_wr_in,
	input wire logic [7:0] cpu_wdata_in,
	input wire logic dbg_wr_in,
	input wire logic [7:0] dbg_wdata_in,
	input wire logic stop_instr_in,
	input wire logic lfo_tick_in,
	input wire logic comparator_in,
	input wire logic timer_pin_in,
	output logic [7:0] cpu_rdata_out,
	output logic force_reset_out,
	output logic srs_clear_out,
	output logic watchdog_enable_out,
	output logic watchdog_long_timeout_out,
	output logic watchdog_clock_select_out,
	output logic watchdog_tick_out,
	output logic stop_mode_allow_out,
	output logic stop_enter_out,
	output logic illegal_opcode_reset_out,
	output logic debug_pin_enable_out,
	output logic reset_pin_enable_out,
	output logic reset_pin_pullup_out,
	output logic i2c_pin_select_out,
	output logic comparator_to_capture_out,
	output logic timer_ch0_out
);
	sysopt_state_t st_ff;
	sysopt_state_t nxt_st;
	// Reset pin enable lives apart: non-power resets must leave it alone
	logic reset_pin_enable_ff;
	logic nxt_reset_pin_enable;
	logic opt1_wr;
	logic opt2_wr;

	// Accepted CPU writes, one per register so the locks stay separate
	// A refused write leaves no trace; software cannot tell it was dropped
	assign opt1_wr = cpu_wr_in && cpu_sel_in == SYSOPT_SEL_OPT1 &&
		!st_ff.opt1_locked;
	assign opt2_wr = cpu_wr_in && cpu_sel_in == SYSOPT_SEL_OPT2;

	// Reset pin enable: cleared while a power reset is held
	// Unknown until the first power reset; the system must start with one
	assign nxt_reset_pin_enable = por_lvd_in ? SYSOPT_RESET_PIN_ENABLE_POR :
		(opt1_wr ? cpu_wdata_in[SYSOPT_O1_RST_PIN] : reset_pin_enable_ff);

	always_ff @(posedge clock_in) begin
		reset_pin_enable_ff <= nxt_reset_pin_enable;
	end

	// Next state of the bank apart from the reset pin enable
	always_comb begin
		nxt_st = st_ff;
		// Option one stores masked data on its first write only
		if (opt1_wr) begin
			nxt_st.opt1 = cpu_wdata_in & SYSOPT_O1_MASK;
			nxt_st.opt1_locked = 1'b1;
		end
		// Option two: pin and routing bits stay writable
		if (opt2_wr) begin
			nxt_st.i2c_pin_sel = cpu_wdata_in[SYSOPT_O2_I2C_PIN];
			nxt_st.cmp_to_cap = cpu_wdata_in[SYSOPT_O2_CMP_CAP];
			nxt_st.wdog_clk_locked = 1'b1;
			if (!st_ff.wdog_clk_locked) begin
				nxt_st.wdog_clk_sel = cpu_wdata_in[SYSOPT_O2_WDOG_CLK];
			end
		end
		// Read data, registered one cycle after the strobe
		// Unmapped select reads zero; a read never changes any state
		nxt_st.rdata = 8'h00;
		if (cpu_rd_in) begin
			unique case (cpu_sel_in)
				SYSOPT_SEL_DBG: nxt_st.rdata = SYSOPT_DBG_READ;
				SYSOPT_SEL_OPT1: nxt_st.rdata = {st_ff.opt1[7:1], reset_pin_enable_ff};
				SYSOPT_SEL_OPT2: begin
					nxt_st.rdata[SYSOPT_O2_WDOG_CLK] = st_ff.wdog_clk_sel;
					nxt_st.rdata[SYSOPT_O2_I2C_PIN] = st_ff.i2c_pin_sel;
					nxt_st.rdata[SYSOPT_O2_CMP_CAP] = st_ff.cmp_to_cap;
				end
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		// Only the debug port reaches the force bit; CPU writes never do
		nxt_st.force_reset = dbg_wr_in &&
			dbg_wdata_in[SYSOPT_FRC_BIT];
		nxt_st.srs_clear = nxt_st.force_reset;
		// Watchdog tick: bus clock runs every cycle, else the slow tick
		// The timeout count itself belongs to the watchdog, not to this bank
		nxt_st.wdog_tick = st_ff.opt1[SYSOPT_O1_WDOG_EN] &&
			(st_ff.wdog_clk_sel || lfo_tick_in);
		// Stop decode: refused stop becomes an illegal opcode reset
		// Both pulses need opposite values of the stop allow bit, so they can never overlap
		nxt_st.stop_enter = stop_instr_in &&
			st_ff.opt1[SYSOPT_O1_STOP_OK];
		nxt_st.illegal_stop = stop_instr_in &&
			!st_ff.opt1[SYSOPT_O1_STOP_OK];
		// Capture channel 0 from comparator or from its own pin
		// Registered routing: channel 0 lags its source by one cycle
		nxt_st.timer_ch0 = st_ff.cmp_to_cap ? comparator_in :
			timer_pin_in;
	end

	// State register; every field has a constant reset value
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff.opt1 <= SYSOPT_O1_RESET;
			st_ff.opt1_locked <= 1'b0;
			st_ff.wdog_clk_sel <= SYSOPT_O2_CLK_RESET;
			st_ff.wdog_clk_locked <= 1'b0;
			st_ff.i2c_pin_sel <= SYSOPT_O2_I2C_RESET;
			st_ff.cmp_to_cap <= SYSOPT_O2_CMP_RESET;
			st_ff.rdata <= 8'h00;
			st_ff.force_reset <= 1'b0;
			st_ff.srs_clear <= 1'b0;
			st_ff.wdog_tick <= 1'b0;
			st_ff.illegal_stop <= 1'b0;
			st_ff.stop_enter <= 1'b0;
			st_ff.timer_ch0 <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from flip-flops
	assign cpu_rdata_out = st_ff.rdata;
	assign force_reset_out = st_ff.force_reset;
	assign srs_clear_out = st_ff.srs_clear;
	assign watchdog_enable_out = st_ff.opt1[SYSOPT_O1_WDOG_EN];
	assign watchdog_long_timeout_out =
		st_ff.opt1[SYSOPT_O1_WDOG_LONG];
	assign watchdog_clock_select_out = st_ff.wdog_clk_sel;
	assign watchdog_tick_out = st_ff.wdog_tick;
	assign stop_mode_allow_out = st_ff.opt1[SYSOPT_O1_STOP_OK];
	assign stop_enter_out = st_ff.stop_enter;
	assign illegal_opcode_reset_out = st_ff.illegal_stop;
	assign debug_pin_enable_out = st_ff.opt1[SYSOPT_O1_DBG_PIN];
	// Pullup is on exactly when the pin acts as reset
	assign reset_pin_enable_out = reset_pin_enable_ff;
	assign reset_pin_pullup_out = reset_pin_enable_ff;
	assign i2c_pin_select_out = st_ff.i2c_pin_sel;
	assign comparator_to_capture_out = st_ff.cmp_to_cap;
	assign timer_ch0_out = st_ff.timer_ch0;

	// Checks of the bank against its intended behaviour
	// They rest during reset; one power reset check runs through it
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	AST_DBG_READ_ZERO: assert property (
		cpu_rd_in && cpu_sel_in == SYSOPT_SEL_DBG |=> cpu_rdata_out == 8'h00)
		else $error("force reset register read not zero");
	AST_CPU_WR_NO_FORCE: assert property (
		cpu_wr_in && cpu_sel_in == SYSOPT_SEL_DBG && !dbg_wr_in
		|=> !force_reset_out)
		else $error("user write forced a reset");
	AST_DBG_FORCE: assert property (
		dbg_wr_in |=> force_reset_out == $past(dbg_wdata_in[0]))
		else $error("debug force write mishandled");
	AST_OPT1_LOCKED: assert property (
		st_ff.opt1_locked |=> $stable(st_ff.opt1) && $stable(reset_pin_enable_ff)
		&& st_ff.opt1_locked)
		else $error("option one changed after lock");
	// Reserved bit four and its neighbours land like any other field
	AST_OPT1_FIRST_WR: assert property (
		cpu_wr_in && cpu_sel_in == SYSOPT_SEL_OPT1 && !st_ff.opt1_locked
		|=> st_ff.opt1[7:4] == $past(cpu_wdata_in[7:4]))
		else $error("option one first write not stored");
	AST_WDOG_OFF: assert property (
		!watchdog_enable_out ##1 !watchdog_enable_out |-> !watchdog_tick_out)
		else $error("watchdog ticks while disabled");
	AST_WDOG_BUS_CLK: assert property (
		watchdog_enable_out && watchdog_clock_select_out
		##1 $stable(watchdog_enable_out) |-> watchdog_tick_out)
		else $error("bus clock watchdog does not tick");
	AST_STOP_REFUSED: assert property (
		stop_instr_in && !stop_mode_allow_out
		|=> illegal_opcode_reset_out && !stop_enter_out)
		else $error("refused stop did not reset");
	AST_CLK_ONCE: assert property (
		st_ff.wdog_clk_locked |=> $stable(watchdog_clock_select_out))
		else $error("watchdog clock select rewritten");
	AST_CH0_ROUTE: assert property (
		comparator_to_capture_out ##1 comparator_to_capture_out
		|-> timer_ch0_out == $past(comparator_in))
		else $error("comparator not routed to channel 0");
	AST_SRS_CLEAR: assert property (
		force_reset_out |-> srs_clear_out)
		else $error("forced reset left source flags");
	AST_PULLUP: assert property (
		reset_pin_pullup_out == reset_pin_enable_out)
		else $error("reset pin pullup mismatch");

	// Fields of option one follow their first write on the next cycle
	AST_LONG_WR: assert property (
		opt1_wr |=> watchdog_long_timeout_out ==
		$past(cpu_wdata_in[SYSOPT_O1_WDOG_LONG]))
		else $error("watchdog timeout bit not stored");

	AST_DBG_PIN_WR: assert property (
		opt1_wr |=> debug_pin_enable_out ==
		$past(cpu_wdata_in[SYSOPT_O1_DBG_PIN]))
		else $error("debug pin enable not stored");

	AST_RESET_PIN_ENABLE_WR: assert property (
		opt1_wr |=> reset_pin_enable_out ==
		$past(cpu_wdata_in[SYSOPT_O1_RST_PIN]))
		else $error("reset pin enable not stored");

	// The debug pin must be usable by a host right after any reset
	AST_DBG_PIN_RESET: assert property (
		$fell(rst_in) |-> debug_pin_enable_out)
		else $error("debug pin not enabled after reset");

	// Power resets clear the reset pin enable, so this one runs in reset
	AST_RESET_PIN_ENABLE_POWER: assert property (
		disable iff (1'b0)
		por_lvd_in |=> !reset_pin_enable_out)
		else $error("reset pin enable survived power reset");

	// Only the debug port can raise the force pulse
	AST_FORCE_ONLY_DBG: assert property (
		force_reset_out |-> $past(dbg_wr_in))
		else $error("force pulse without debug write");

	// Stop is decoded both ways, and the reset has no other cause
	AST_STOP_ALLOWED: assert property (
		stop_instr_in && stop_mode_allow_out
		|=> stop_enter_out && !illegal_opcode_reset_out)
		else $error("allowed stop not entered");

	AST_ILOP_CAUSE: assert property (
		illegal_opcode_reset_out
		|-> $past(stop_instr_in) && !$past(stop_mode_allow_out))
		else $error("illegal opcode reset without refused stop");

	// Option two routing bits stay writable after the clock lock
	AST_I2C_WR: assert property (
		opt2_wr |=> i2c_pin_select_out ==
		$past(cpu_wdata_in[SYSOPT_O2_I2C_PIN]))
		else $error("i2c pin select not stored");

	AST_CAPT_WR: assert property (
		opt2_wr |=> comparator_to_capture_out ==
		$past(cpu_wdata_in[SYSOPT_O2_CMP_CAP]))
		else $error("comparator routing not stored");

	AST_CH0_PIN: assert property (
		!comparator_to_capture_out
		|=> timer_ch0_out == $past(timer_pin_in))
		else $error("timer pin not routed to channel 0");

	// Slow clock path: the watchdog steps once per slow tick
	AST_WDOG_LFO: assert property (
		watchdog_enable_out && !watchdog_clock_select_out
		|=> watchdog_tick_out == $past(lfo_tick_in))
		else $error("watchdog does not follow slow tick");

	// A write to one register must leave the other's lock open
	AST_OPT2_KEEPS_OPT1: assert property (
		opt2_wr && !st_ff.opt1_locked |=> !st_ff.opt1_locked)
		else $error("option two write locked option one");

	AST_OPT1_KEEPS_CLK: assert property (
		opt1_wr && !st_ff.wdog_clk_locked |=> !st_ff.wdog_clk_locked)
		else $error("option one write locked clock select");

	// Scenarios that the bench is expected to reach
	COV_FORCE: cover property (dbg_wr_in && dbg_wdata_in[0] ##1
		force_reset_out);
	COV_LOCK_THEN_WR: cover property (st_ff.opt1_locked && cpu_wr_in &&
		cpu_sel_in == SYSOPT_SEL_OPT1);
	COV_ILLEGAL_STOP: cover property (illegal_opcode_reset_out);
	COV_CLK_REWRITE: cover property (st_ff.wdog_clk_locked && opt2_wr);
	COV_WARM_KEEPS_RESET_PIN_ENABLE: cover property ($fell(rst_in) &&
		reset_pin_enable_out);
endmodule // sysopt_bank

/* bench/sysopt_host_model.sv */
// Debug host model: byte writes to the force reset register.
// Assumes the bench pulses req_in for one clock per write.
module sysopt_host_model (
	input wire logic clock_in,
	input wire logic req_in,
	input wire logic [1:0] delay_in,
	input wire logic [7:0] data_in,
	output logic dbg_wr_out,
	output logic [7:0] dbg_wdata_out,
	output logic mode_pin_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic armed_ff = 1'b0;
	logic [1:0] wait_ff = 2'h0;
	logic [7:0] data_ff = 8'h00;
	initial dbg_wr_out = 1'b0;
	initial dbg_wdata_out = 8'h00;
	initial mode_pin_out = 1'b0;
	// Idle data toggles so a stale byte never looks valid
	always @(posedge clock_in) begin
		if (req_in) begin
			armed_ff <= 1'b1;
			wait_ff <= delay_in;
			data_ff <= data_in;
		end else if (armed_ff && wait_ff != 2'h0) begin
			wait_ff <= wait_ff - 2'h1; // Slow host
		end else if (armed_ff) begin
			armed_ff <= 1'b0;
		end
		// Each output is given at most one value per edge; mode_pin_out only on a write
		if (!req_in && armed_ff && wait_ff == 2'h0) begin
			dbg_wr_out <= 1'b1;
			dbg_wdata_out <= data_ff;
			mode_pin_out <= 1'b1;
		end else begin
			dbg_wr_out <= 1'b0;
			dbg_wdata_out <= ~dbg_wdata_out;
		end
	end
endmodule // sysopt_host_model

/* bench/test_system_option_registers.sv */
// Testbench of the option register bank with a debug host model.
// Assumes the system turns a forced reset into rst_in.
module test_system_option_registers;
	timeunit 1ns;
	timeprecision 100ps;
	import sysopt_pkg::*;
	logic clk = 1'b0, rst = 1'b1, por = 1'b1, rd = 1'b0, wr = 1'b0;
	logic stp = 1'b0, cmp = 1'b0, tpin = 1'b1, req = 1'b0, lfo = 1'b0;
	logic [1:0] sel = 2'h0, hdl = 2'h0;
	logic [7:0] wd = 8'h00, hd = 8'h00, rdat, dwd;
	logic dwr, frc, reset_source_status, wen, wlong, wclk, tick, stop_ok, stop_go, ilop;
	logic dpin, rpin, pull, i2c, capt, ch0;
	int fail_count = 0, checks_done = 0;
	sysopt_host_model sysopt_host_model_i (.clock_in(clk), .req_in(req),
		.delay_in(hdl), .data_in(hd), .dbg_wr_out(dwr),
		.dbg_wdata_out(dwd), .mode_pin_out());
	sysopt_bank sysopt_bank_i (.clock_in(clk), .rst_in(rst),
		.por_lvd_in(por), .cpu_sel_in(sel), .cpu_rd_in(rd),
		.cpu_wr_in(wr), .cpu_wdata_in(wd), .dbg_wr_in(dwr),
		.dbg_wdata_in(dwd), .stop_instr_in(stp), .lfo_tick_in(lfo),
		.comparator_in(cmp), .timer_pin_in(tpin), .cpu_rdata_out(rdat),
		.force_reset_out(frc), .srs_clear_out(reset_source_status),
		.watchdog_enable_out(wen), .watchdog_long_timeout_out(wlong),
		.watchdog_clock_select_out(wclk), .watchdog_tick_out(tick),
		.stop_mode_allow_out(stop_ok), .stop_enter_out(stop_go),
		.illegal_opcode_reset_out(ilop), .debug_pin_enable_out(dpin),
		.reset_pin_enable_out(rpin), .reset_pin_pullup_out(pull),
		.i2c_pin_select_out(i2c), .comparator_to_capture_out(capt),
		.timer_ch0_out(ch0));
	// Bus clock, 4 ns period
	always #2 clk = ~clk;
	task automatic chk_byte(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_bit(input string n, input logic e, g);
		chk_byte(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Any MCU reset; p marks a power or low-voltage reset
	task automatic do_reset(input logic p);
		@(posedge clk) {rst, por} <= {1'b1, p};
		repeat (12) @(posedge clk);
		{rst, por} <= 2'h0;
	endtask
	// Write strobe taken at the second edge; effect settled after it
	task automatic cpu_wr(input logic [1:0] s, input logic [7:0] d);
		@(posedge clk) {sel, wd, wr} <= {s, d, 1'b1};
		@(posedge clk) wr <= 1'b0;
		#1;
	endtask
	task automatic cpu_rd(input logic [1:0] s, input logic [7:0] e,
		input string n);
		@(posedge clk) {sel, rd} <= {s, 1'b1};
		@(posedge clk) rd <= 1'b0;
		#1 chk_byte(n, e, rdat);
	endtask
	// Host byte write; a forced reset must pulse once, then is applied
	task automatic host(input logic [7:0] d, input logic [1:0] dl,
		input logic e);
		int seen;
		seen = 0;
		@(posedge clk) {req, hd, hdl} <= {1'b1, d, dl};
		@(posedge clk) req <= 1'b0;
		repeat (8) begin
			@(posedge clk) #1;
			if (frc === 1'b1) seen++;
			if (frc === 1'b1) chk_bit("srs_clear", 1'b1, reset_source_status);
		end
		chk_bit("force_reset", e, seen == 1);
		// A lost force is already a mismatch; the run goes on unreset
		if (seen != 0) do_reset(1'b0);
	endtask
	task automatic stop_try(input logic ok);
		@(posedge clk) stp <= 1'b1;
		@(posedge clk) stp <= 1'b0;
		#1 chk_bit("stop_enter", ok, stop_go);
		chk_bit("illegal_stop", !ok, ilop);
	endtask
	task automatic t_reset_values();
		cpu_rd(SYSOPT_SEL_OPT1, 8'hD2, "opt1 power");
		cpu_rd(SYSOPT_SEL_OPT2, 8'h00, "opt2 reset");
		cpu_rd(2'h3, 8'h00, "unmapped");
		chk_bit("debug_pin", 1'b1, dpin);
		chk_bit("reset_pin", 1'b0, rpin);
		chk_bit("stop_allow", 1'b0, stop_ok);
		chk_bit("wdog_en", 1'b1, wen);
		chk_bit("wdog_clk", 1'b0, wclk);
		chk_bit("capture", 1'b0, capt);
		// Slow clock selected: the tick follows it one cycle late
		@(posedge clk) lfo <= 1'b1;
		@(posedge clk) lfo <= 1'b0;
		#1 chk_bit("tick slow", 1'b1, tick);
		@(posedge clk) #1 chk_bit("tick idle", 1'b0, tick);
		$display("test reset values done");
	endtask
	task automatic t_debug();
		cpu_wr(SYSOPT_SEL_DBG, 8'h01);
		chk_bit("cpu force", 1'b0, frc);
		cpu_rd(SYSOPT_SEL_DBG, 8'h00, "force reg");
		host(8'hFE, 2'h0, 1'b0);
		host(8'h01, 2'h3, 1'b1);
		$display("test debug force done");
	endtask
	task automatic t_opt1();
		cpu_wr(SYSOPT_SEL_OPT1, 8'h6D);
		cpu_rd(SYSOPT_SEL_OPT1, 8'h61, "opt1 first");
		chk_bit("wdog_en", 1'b0, wen);
		chk_bit("wdog_long", 1'b1, wlong);
		chk_bit("debug_pin", 1'b0, dpin);
		chk_bit("pullup", 1'b1, pull);
		chk_bit("reset_pin", 1'b1, rpin);
		chk_bit("stop_allow", 1'b1, stop_ok);
		cpu_wr(SYSOPT_SEL_OPT1, 8'h92);
		cpu_rd(SYSOPT_SEL_OPT1, 8'h61, "opt1 second");
		stop_try(1'b1);
		$display("test option one done");
	endtask
	task automatic t_opt2();
		cpu_wr(SYSOPT_SEL_OPT2, 8'h83);
		cpu_wr(SYSOPT_SEL_OPT2, 8'h00);
		cpu_rd(SYSOPT_SEL_OPT2, 8'h80, "opt2 lock");
		chk_bit("wdog_clk", 1'b1, wclk);
		chk_bit("i2c", 1'b0, i2c);
		@(posedge clk) {cmp, tpin} <= 2'h2;
		@(posedge clk) #1 chk_bit("ch0 pin", 1'b0, ch0);
		chk_bit("tick off", 1'b0, tick);
		cpu_wr(SYSOPT_SEL_OPT2, 8'h03);
		chk_bit("i2c", 1'b1, i2c);
		chk_bit("capture", 1'b1, capt);
		@(posedge clk) #1 chk_bit("ch0 cmp", 1'b1, ch0);
		$display("test option two done");
	endtask
	task automatic t_warm();
		host(8'h01, 2'h0, 1'b1);
		cpu_rd(SYSOPT_SEL_OPT1, 8'hD3, "opt1 warm");
		do_reset(1'b1);
		cpu_rd(SYSOPT_SEL_OPT1, 8'hD2, "opt1 power again");
		cpu_wr(SYSOPT_SEL_OPT2, 8'h80);
		@(posedge clk) #1 chk_bit("tick bus", 1'b1, tick);
		cpu_wr(SYSOPT_SEL_OPT1, 8'h00);
		cpu_rd(SYSOPT_SEL_OPT1, 8'h00, "opt1 own lock");
		chk_bit("wdog_long", 1'b0, wlong);
		stop_try(1'b0);
		$display("test warm reset done");
	endtask
	// Power reset first, then the scenarios in turn
	initial begin
		repeat (12) @(posedge clk);
		{rst, por} <= 2'h0;
		t_reset_values();
		t_debug();
		t_opt1();
		t_opt2();
		t_warm();
		conclude();
	end
endmodule // test_system_option_registers
